// ---- logic/lfs_supervisor.sv ----
// Operation
// - overvoltage drops both drives, asserts fault
// - hold until overvoltage clears past hysteresis
// - boost: hiccup after three overcurrent cycles
// - dim drive low for whole hiccup
// - short: gate low, loop reset, 16000 cycles
// - after off interval, release and restart
// - persisting overcurrent repeats the hiccup sequence
// - cleared overcurrent resumes normal regulation
// - no hiccup in buck-boost or SEPIC
// - over 165C: standby and fault flag
// - stay standby until below 145C
// - level below 0.1V turns output off
// - above 1.1V full-scale, below proportional
`timescale 1ns/1ns
`include "lfs_params.svh"

module lfs_supervisor (
    input  wire logic       I_CLK,
    input  wire logic       I_RESETN,
    input  wire logic       I_OVERVOLTAGE_SENSE,
    input  wire logic       I_STRING_OVERCURRENT,
    input  wire logic       I_TEMP_HOT,
    input  wire logic       I_TEMP_COOL,
    input  wire logic       I_LEVEL_LOW,
    input  wire logic       I_LEVEL_FULL,
    input  wire logic       I_PWM_EN,
    input  wire logic [1:0] I_TOPOLOGY,
    output logic            O_GATE_DRIVE,
    output logic            O_DIM_SWITCH_DRIVE,
    output logic            O_FAULT_FLAG_N_O,
    output logic            O_FAULT_FLAG_N_OE,
    output logic            O_LOOP_RESET,
    output logic            O_FULL_SCALE
);
    localparam int SYNC_W = 7;
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    logic [SYNC_W-1:0] s3_q;
    logic [SYNC_W-1:0] filt_q;
    logic [SYNC_W-1:0] raw;
    lfs_pkg::lfs_cmp_t cmp;
    logic              pwm_q;

    assign raw = {I_PWM_EN, I_OVERVOLTAGE_SENSE, I_STRING_OVERCURRENT,
                  I_TEMP_HOT, I_TEMP_COOL, I_LEVEL_LOW, I_LEVEL_FULL};

    // three-stage sync
    // a change is taken once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_sync
            always_ff @(posedge I_CLK or negedge I_RESETN) begin
                if (!I_RESETN) begin
                    s1_q[g]   <= 1'b0;
                    s2_q[g]   <= 1'b0;
                    s3_q[g]   <= 1'b0;
                    filt_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        filt_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    assign cmp   = filt_q[5:0];
    assign pwm_q = filt_q[6];

    logic ov_fault_q;
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ov_fault_q <= 1'b0;
        end else begin
            ov_fault_q <= cmp.ov;
        end
    end

    logic th_fault_q;
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            th_fault_q <= 1'b0;
        end else if (cmp.hot) begin
            th_fault_q <= 1'b1;
        end else if (cmp.cool) begin
            th_fault_q <= 1'b0;
        end
    end

    // short-circuit hiccup machine
    lfs_pkg::lfs_sc_state_t      sc_q;
    logic [`LFS_CNT_W-1:0]       cnt_q;
    logic                        boost;
    assign boost = (I_TOPOLOGY == `LFS_TOPO_BOOST);

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sc_q  <= lfs_pkg::LFS_RUN;
            cnt_q <= '0;
        end else begin
            case (sc_q)
                lfs_pkg::LFS_RUN: begin
                    cnt_q <= '0;
                    if (cmp.oc && boost) begin
                        sc_q  <= lfs_pkg::LFS_OC_DLY;
                        cnt_q <= `LFS_CNT_W'(1);
                    end
                end
                lfs_pkg::LFS_OC_DLY: begin
                    if (!cmp.oc || !boost) begin
                        sc_q <= lfs_pkg::LFS_RUN;
                    end else if (cnt_q >= `LFS_CNT_W'(`LFS_OC_DELAY_CYC)) begin
                        sc_q  <= lfs_pkg::LFS_HICCUP;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + `LFS_CNT_W'(1);
                    end
                end
                lfs_pkg::LFS_HICCUP: begin
                    // re-detect from run on persisting fault
                    if (cnt_q == `LFS_CNT_W'(`LFS_HICCUP_CYC - 1)) begin
                        sc_q  <= lfs_pkg::LFS_RUN;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + `LFS_CNT_W'(1);
                    end
                end
                default: begin
                    sc_q  <= lfs_pkg::LFS_RUN;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    logic sc_fault;
    assign sc_fault = (sc_q == lfs_pkg::LFS_HICCUP);

    // output stage: every output except the constant O_FAULT_FLAG_N_O from a flip-flop
    logic any_stop;
    assign any_stop = ov_fault_q | th_fault_q | sc_fault | cmp.lvl_low;

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_GATE_DRIVE       <= `LFS_RST_GATE;
            O_DIM_SWITCH_DRIVE <= `LFS_RST_DIM;
            O_FAULT_FLAG_N_OE  <= ~`LFS_RST_FAULT_N;
            O_LOOP_RESET       <= `LFS_RST_LOOP;
            O_FULL_SCALE       <= `LFS_RST_FULL;
        end else begin
            O_GATE_DRIVE       <= !any_stop;
            O_DIM_SWITCH_DRIVE <= !any_stop && pwm_q;
            // fault is the OR of faults
            O_FAULT_FLAG_N_OE  <= ov_fault_q | th_fault_q | sc_fault;
            O_LOOP_RESET       <= ov_fault_q | th_fault_q | sc_fault;
            O_FULL_SCALE       <= cmp.lvl_full;
        end
    end

    // open-drain: only ever pulls low
    assign O_FAULT_FLAG_N_O = 1'b0;

    // all checks run on the switching clock, quiet in reset
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESETN);

    ov_drop_a: assert property (
        ov_fault_q |=> !O_GATE_DRIVE && !O_DIM_SWITCH_DRIVE
                       && O_FAULT_FLAG_N_OE)
        else $error("overvoltage did not drop drives");
    ov_hold_a: assert property (
        cmp.ov |-> ##2 (!O_GATE_DRIVE && !O_DIM_SWITCH_DRIVE
                        && O_FAULT_FLAG_N_OE))
        else $error("overvoltage hold released early");
    oc_delay_a: assert property (
        $rose(sc_fault) |-> $past(cmp.oc, 1) && $past(cmp.oc, 2))
        else $error("hiccup began without qualified overcurrent");
    hiccup_dim_a: assert property (
        sc_fault |=> !O_DIM_SWITCH_DRIVE && !O_GATE_DRIVE)
        else $error("drive high during hiccup");
    hiccup_len_a: assert property (
        $rose(sc_fault) |-> sc_fault [*8])
        else $error("hiccup interval too short");
    hiccup_end_a: assert property (
        sc_fault && cnt_q == `LFS_CNT_W'(`LFS_HICCUP_CYC - 1)
        |=> sc_q == lfs_pkg::LFS_RUN)
        else $error("hiccup did not end");
    resume_a: assert property (
        $fell(sc_fault) && !ov_fault_q && !th_fault_q && !cmp.lvl_low
        |=> O_GATE_DRIVE)
        else $error("drives not released after hiccup");
    no_boost_a: assert property (
        !boost && sc_q == lfs_pkg::LFS_RUN |=> sc_q == lfs_pkg::LFS_RUN)
        else $error("hiccup outside boost");
    thermal_off_a: assert property (
        th_fault_q |=> !O_GATE_DRIVE && !O_DIM_SWITCH_DRIVE
                       && O_FAULT_FLAG_N_OE)
        else $error("thermal fault left drives on");
    thermal_a: assert property (
        th_fault_q && !cmp.cool |=> th_fault_q)
        else $error("thermal standby left early");
    level_off_a: assert property (
        cmp.lvl_low |=> !O_GATE_DRIVE)
        else $error("output on with low level");
    full_scale_a: assert property (
        cmp.lvl_full |=> O_FULL_SCALE)
        else $error("full scale not selected");
    fault_or_a: assert property (
        !ov_fault_q && !th_fault_q && !sc_fault |=> !O_FAULT_FLAG_N_OE)
        else $error("fault flag without a fault");

    ov_c: cover property ($rose(ov_fault_q));
    hiccup_c: cover property ($fell(sc_fault));
    thermal_c: cover property ($fell(th_fault_q));
    retry_c: cover property ($fell(sc_fault) ##[1:20] $rose(sc_fault));
    level_c: cover property ($rose(cmp.lvl_low));
endmodule

// ---- common/lfs_params.svh ----
`ifndef LFS_PARAMS_SVH
`define LFS_PARAMS_SVH
// timing counts, in switching-clock cycles, and the counter width in bits
`define LFS_OC_DELAY_CYC    2
`define LFS_HICCUP_CYC      16000
`define LFS_CNT_W           14
// reset values of the pin outputs
`define LFS_RST_GATE        1'b0
`define LFS_RST_DIM         1'b0
`define LFS_RST_FAULT_N     1'b1
`define LFS_RST_LOOP        1'b1
`define LFS_RST_FULL        1'b0
// topology codes
`define LFS_TOPO_BOOST      2'b00
`define LFS_TOPO_BUCKBOOST  2'b01
`define LFS_TOPO_SEPIC      2'b10
`endif

// ---- common/lfs_pkg.sv ----
package lfs_pkg;
    typedef enum logic [1:0] {
        LFS_RUN    = 2'b00,
        LFS_OC_DLY = 2'b01,
        LFS_HICCUP = 2'b10
    } lfs_sc_state_t;

    typedef struct packed {
        logic ov;
        logic oc;
        logic hot;
        logic cool;
        logic lvl_low;
        logic lvl_full;
    } lfs_cmp_t;
endpackage

// ---- tb/lfs_load_model.sv ----
`timescale 1ns/1ns
module lfs_load_model (
    input  wire logic i_gate,
    input  wire logic i_dim,
    input  wire logic i_short,
    input  wire logic i_flag_o,
    input  wire logic i_flag_oe,
    output logic      o_overcurrent,
    output logic      o_flag_pin
);
    // a shorted string only draws current while both switches conduct
    assign o_overcurrent = i_short & i_gate & i_dim;
    // host pull-up: a released pin reads high, never the last value
    assign o_flag_pin = i_flag_oe ? i_flag_o : 1'b1;
endmodule

// ---- tb/lfs_supervisor_tb.sv ----
`timescale 1ns/1ns
module lfs_supervisor_tb;
    logic       clk  = 1'b0;
    logic       rst_n = 1'b0;
    logic       ov = 1'b0, hot = 1'b0, cool = 1'b1, low = 1'b0;
    logic       full = 1'b1, pwm = 1'b1, shrt = 1'b0;
    logic [1:0] topo = 2'b00;
    logic       oc, gate, dim, fo, foe, lr, fs, pin;
    int         bad_count = 0;
    int         checked = 0;

    always #5 clk = ~clk;

    lfs_supervisor dut_u (.I_CLK(clk), .I_RESETN(rst_n),
        .I_OVERVOLTAGE_SENSE(ov), .I_STRING_OVERCURRENT(oc),
        .I_TEMP_HOT(hot), .I_TEMP_COOL(cool), .I_LEVEL_LOW(low),
        .I_LEVEL_FULL(full), .I_PWM_EN(pwm), .I_TOPOLOGY(topo),
        .O_GATE_DRIVE(gate), .O_DIM_SWITCH_DRIVE(dim),
        .O_FAULT_FLAG_N_O(fo), .O_FAULT_FLAG_N_OE(foe),
        .O_LOOP_RESET(lr), .O_FULL_SCALE(fs));

    lfs_load_model load_u (.i_gate(gate), .i_dim(dim), .i_short(shrt),
        .i_flag_o(fo), .i_flag_oe(foe), .o_overcurrent(oc),
        .o_flag_pin(pin));

    // inputs move and outputs are read 1 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic seen, input logic exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t got %b exp %b", $time, seen, exp);
        end
    endtask

    task automatic wdim(input logic v, input int n);
        int k;
        k = 0;
        while (dim !== v && k < n) begin
            cyc(1);
            k++;
        end
        chk(dim, v);
    endtask

    task automatic test_done;
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic t_ovp;
        ov = 1'b1;
        cyc(8);
        chk(gate, 1'b0);
        chk(dim, 1'b0);
        chk(pin, 1'b0);
        cyc(20);
        chk(gate, 1'b0);
        chk(pin, 1'b0);
        ov = 1'b0;
        cyc(8);
        chk(gate, 1'b1);
        chk(pin, 1'b1);
    endtask

    task automatic t_therm;
        hot = 1'b1;
        cool = 1'b0;
        cyc(8);
        chk(gate, 1'b0);
        chk(pin, 1'b0);
        hot = 1'b0;
        cyc(20);
        chk(gate, 1'b0);
        chk(pin, 1'b0);
        cool = 1'b1;
        cyc(8);
        chk(gate, 1'b1);
        chk(pin, 1'b1);
    endtask

    task automatic t_level;
        low = 1'b1;
        full = 1'b0;
        cyc(8);
        chk(gate, 1'b0);
        chk(pin, 1'b1);
        low = 1'b0;
        cyc(8);
        chk(gate, 1'b1);
        chk(fs, 1'b0);
        full = 1'b1;
        cyc(8);
        chk(fs, 1'b1);
        // dimming low only opens the string switch
        pwm = 1'b0;
        cyc(8);
        chk(dim, 1'b0);
        chk(gate, 1'b1);
        pwm = 1'b1;
        cyc(8);
    endtask

    task automatic t_short;
        // a one-cycle spike must not start a hiccup
        shrt = 1'b1;
        cyc(1);
        shrt = 1'b0;
        cyc(12);
        chk(dim, 1'b1);
        chk(pin, 1'b1);
        shrt = 1'b1;
        cyc(10);
        chk(dim, 1'b0);
        chk(gate, 1'b0);
        chk(lr, 1'b1);
        chk(pin, 1'b0);
        cyc(15980);
        chk(dim, 1'b0);
        wdim(1'b1, 40);
        wdim(1'b0, 15);
        shrt = 1'b0;
        wdim(1'b1, 16100);
        cyc(50);
        chk(dim, 1'b1);
        chk(gate, 1'b1);
        chk(lr, 1'b0);
    endtask

    task automatic t_nonboost;
        for (int t = 1; t < 3; t++) begin
            topo = t[1:0];
            shrt = 1'b1;
            cyc(30);
            chk(dim, 1'b1);
            chk(pin, 1'b1);
            chk(lr, 1'b0);
            shrt = 1'b0;
            // let the filtered short die out before boost returns
            cyc(8);
        end
        topo = 2'b00;
    endtask

    initial begin
        cyc(6);
        chk(gate, 1'b0);
        chk(lr, 1'b1);
        rst_n = 1'b1;
        cyc(10);
        chk(gate, 1'b1);
        chk(dim, 1'b1);
        t_ovp();
        t_therm();
        t_level();
        t_nonboost();
        t_short();
        test_done();
    end

    // whole run is about 32300 cycles; hiccups dominate
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        test_done();
    end
endmodule
